//--- hdl/wake_status_regs.svh
// Register offsets, field positions, reset values and masks of the wake status block
`ifndef WAKE_STATUS_REGS_SVH
`define WAKE_STATUS_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WAKE_LOW_OFS 12'hF4A
`define WAKE_HIGH_OFS 12'hF4B
`define CONTEXT_ONE_OFS 12'hF4F
`define WDT_CTRL_OFS 12'hF50
`define DEEP_CFG_OFS 12'hF51
`define IRQ_STAT_OFS 12'hF52
`define IRQ_EN_OFS 12'hF53
`define IRQ_CLR_OFS 12'hF54

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FAULT_BIT 7
`define ULP_BIT 5
`define WDOG_BIT 4
`define ALARM_BIT 3
`define RSTPIN_BIT 2
`define POWER_ON_BIT 0
`define EXT_INT_BIT 0
`define FUNC_EN_BIT 0
`define SINK_EN_BIT 1
`define LEVEL_BIT 5
`define DEEP_EN_BIT 1
`define SRC_DIS_BIT 2

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define WAKE_LOW_MASK 8'hBD
`define WAKE_HIGH_MASK 8'h01
`define WAKE_LOW_RST 8'h01
`define WAKE_HIGH_RST 8'h00
`define CONTEXT_RST 8'h00
`define WDT_CTRL_MASK 8'h23
`define DEEP_CFG_MASK 8'h06
`define REG_ZERO 8'h00

// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define SYNC_W 9
`define LN_PIN 0
`define LN_IOC 1
`define LN_FAULT 2
`define LN_WDOG 3
`define LN_ALARM 4
`define LN_RSTPIN 5
`define LN_POWER_ON 6
`define LN_CORE_BO 7
`define LN_DEEP_BO 8

`endif

//--- hdl/wake_status_pkg.sv
// Types shared by the wake status block
package wake_status_pkg;

    // ----------------------------------------
    // Event vector, same layout as the interrupt status
    // ----------------------------------------
    typedef struct packed {
        logic fault;
        logic ext_int;
        logic ulp;
        logic watchdog;
        logic alarm;
        logic reset_pin;
        logic sleep_wake;
        logic power_on;
    } wake_event_type;

    // ----------------------------------------
    // Power mode seen by the block
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } power_mode_type;

endpackage : wake_status_pkg

//--- hdl/deep_sleep_wake_status.sv
// Deep sleep wake source status, persistent context and low-power wake logic
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "wake_status_regs.svh"

// Contract
// RQ1: Eight-bit context register kept across deep sleep
// RQ2: Context lost only on brown-out or power cycle
// RQ3: High byte bit 0 flags interrupt-on-change wake
// RQ4: Low bit 7 flags deep sleep fault
// RQ5: Low bit 5 flags low-power pin wake
// RQ6: Low bit 4 flags deep watchdog expiry
// RQ7: Low bit 3 flags calendar alarm wake
// RQ8: Low bit 2 flags master clear wake
// RQ9: Bit 0 power-on flag, resets one, anytime
// RQ10: Low bits 6 and 1 read zero
// RQ11: Pin below threshold raises wake from sleep
// RQ12: Sleep wake sets level flag bit 5
// RQ13: Software maps wake output and charges capacitor
// RQ14: Software releases pin, enables sink, sleeps
// RQ15: In sleep wake output drives level flag
// RQ16: Deep wake needs enable set, disable clear
// RQ17: Any deep wake starts power-on sequence
// RQ18: Flags stay set until software writes zero
module deep_sleep_wake_status (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Register port
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Power mode and configuration from the core
    input wire logic SLEEP_MODE,
    input wire logic DEEP_SLEEP_MODE,
    input wire logic DEEP_BOR_ENABLE,
    // Asynchronous wake and supply sources
    input wire logic WAKE_PIN_IN,
    input wire logic IOC_IN,
    input wire logic FAULT_IN,
    input wire logic DEEP_WDT_EXPIRED,
    input wire logic ALARM_IN,
    input wire logic MASTER_CLEAR_ASSERTED,
    input wire logic POWER_ON_DETECT,
    input wire logic CORE_BROWNOUT,
    input wire logic DEEP_BROWNOUT,
    // Wake results
    output logic SLEEP_WAKE_REQ,
    output logic POR_SEQ_START,
    output logic WAKE_OUT,
    output logic SINK_EN,
    output logic IRQ
);

    // ----------------------------------------
    // Address decode helper
    // ----------------------------------------
    function automatic logic hit(
        input logic [11:0] a,
        input logic [11:0] ofs
    );
        hit = (a == ofs);
    endfunction : hit

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [`SYNC_W-1:0] async_in;
    logic [`SYNC_W-1:0] meta_q;
    logic [`SYNC_W-1:0] sync_q;

    assign async_in = {
        DEEP_BROWNOUT,
        CORE_BROWNOUT,
        POWER_ON_DETECT,
        MASTER_CLEAR_ASSERTED,
        ALARM_IN,
        DEEP_WDT_EXPIRED,
        FAULT_IN,
        IOC_IN,
        WAKE_PIN_IN
    };

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= async_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Power mode
    // ----------------------------------------
    wake_status_pkg::power_mode_type mode;

    assign mode = DEEP_SLEEP_MODE ? wake_status_pkg::MODE_DEEP :
                  SLEEP_MODE ? wake_status_pkg::MODE_SLEEP :
                  wake_status_pkg::MODE_RUN;

    wire in_deep = (mode == wake_status_pkg::MODE_DEEP);
    wire in_sleep = (mode == wake_status_pkg::MODE_SLEEP);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] wake_low_q;
    logic [7:0] wake_low_d;
    logic [7:0] wake_high_q;
    logic [7:0] wake_high_d;
    logic [7:0] context_q;
    logic [7:0] context_d;
    logic [7:0] wdt_ctrl_q;
    logic [7:0] wdt_ctrl_d;
    logic [7:0] deep_cfg_q;
    logic [7:0] deep_cfg_d;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_stat_d;
    logic [7:0] irq_en_q;
    logic [7:0] irq_en_d;
    logic deep_any_q;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire wr_low = WR && hit(ADDR, `WAKE_LOW_OFS);
    wire wr_high = WR && hit(ADDR, `WAKE_HIGH_OFS);
    wire wr_ctx = WR && hit(ADDR, `CONTEXT_ONE_OFS);
    wire wr_ctrl = WR && hit(ADDR, `WDT_CTRL_OFS);
    wire wr_cfg = WR && hit(ADDR, `DEEP_CFG_OFS);
    wire wr_en = WR && hit(ADDR, `IRQ_EN_OFS);
    wire wr_clr = WR && hit(ADDR, `IRQ_CLR_OFS);

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    wire func_en = wdt_ctrl_q[`FUNC_EN_BIT];
    wire sink_en = wdt_ctrl_q[`SINK_EN_BIT];
    wire level_flag = wdt_ctrl_q[`LEVEL_BIT];
    wire deep_en = deep_cfg_q[`DEEP_EN_BIT];
    wire src_dis = deep_cfg_q[`SRC_DIS_BIT];

    // ----------------------------------------
    // Wake events
    // ----------------------------------------
    // Capacitor discharged below the input threshold
    wire pin_low = !sync_q[`LN_PIN];

    wire ioc_ev = in_deep && sync_q[`LN_IOC]; // RQ3
    wire fault_ev = in_deep && sync_q[`LN_FAULT]; // RQ4
    wire ulp_deep_ev = in_deep && deep_en && !src_dis && pin_low; // RQ5 RQ16
    wire wdog_ev = in_deep && sync_q[`LN_WDOG]; // RQ6
    wire alarm_ev = in_deep && sync_q[`LN_ALARM]; // RQ7
    wire rstpin_ev = in_deep && sync_q[`LN_RSTPIN]; // RQ8
    // Power-on detect may land in any mode
    wire por_ev = sync_q[`LN_POWER_ON]; // RQ9
    // Ordinary sleep wake needs the function armed by software, not the sink
    wire ulp_sleep_ev = in_sleep && func_en && pin_low; // RQ11 RQ14

    wake_status_pkg::wake_event_type ev;

    assign ev = '{
        fault: fault_ev,
        ext_int: ioc_ev,
        ulp: ulp_deep_ev,
        watchdog: wdog_ev,
        alarm: alarm_ev,
        reset_pin: rstpin_ev,
        sleep_wake: ulp_sleep_ev,
        power_on: por_ev
    };

    wire deep_any = ioc_ev || fault_ev || ulp_deep_ev
                  || wdog_ev || alarm_ev || rstpin_ev;

    // ----------------------------------------
    // Wake status bytes
    // ----------------------------------------
    // Hardware set wins over a software write of zero
    wire [7:0] low_set = {
        fault_ev, 1'b0, ulp_deep_ev, wdog_ev,
        alarm_ev, rstpin_ev, 1'b0, por_ev
    };
    wire [7:0] high_set = {7'b000_0000, ioc_ev};

    assign wake_low_d = ((wr_low ? WDATA : wake_low_q) | low_set)
                      & `WAKE_LOW_MASK; // RQ10 RQ18
    assign wake_high_d = ((wr_high ? WDATA : wake_high_q) | high_set)
                       & `WAKE_HIGH_MASK; // RQ3 RQ18

    // ----------------------------------------
    // Persistent context
    // ----------------------------------------
    // A brown-out that counts depends on the mode it strikes in
    wire ctx_loss = (sync_q[`LN_CORE_BO] && !in_deep)
                 || (sync_q[`LN_DEEP_BO] && in_deep && DEEP_BOR_ENABLE);

    assign context_d = ctx_loss ? `CONTEXT_RST :
                       wr_ctx ? WDATA : context_q; // RQ1 RQ2

    // ----------------------------------------
    // Watchdog control and deep configuration
    // ----------------------------------------
    wire [7:0] lvl_set = {2'b00, ulp_sleep_ev, 5'b0_0000};

    assign wdt_ctrl_d = ((wr_ctrl ? WDATA : wdt_ctrl_q) | lvl_set)
                      & `WDT_CTRL_MASK; // RQ12
    assign deep_cfg_d = (wr_cfg ? WDATA : deep_cfg_q) & `DEEP_CFG_MASK;

    // ----------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------
    wire [7:0] clr_mask = wr_clr ? WDATA : `REG_ZERO;

    assign irq_stat_d = (irq_stat_q & ~clr_mask) | ev;
    assign irq_en_d = wr_en ? WDATA : irq_en_q;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [7:0] rd_val =
        hit(ADDR, `WAKE_LOW_OFS) ? wake_low_q :
        hit(ADDR, `WAKE_HIGH_OFS) ? wake_high_q :
        hit(ADDR, `CONTEXT_ONE_OFS) ? context_q :
        hit(ADDR, `WDT_CTRL_OFS) ? wdt_ctrl_q :
        hit(ADDR, `DEEP_CFG_OFS) ? deep_cfg_q :
        hit(ADDR, `IRQ_STAT_OFS) ? irq_stat_q :
        hit(ADDR, `IRQ_EN_OFS) ? irq_en_q :
        `REG_ZERO;

    // ----------------------------------------
    // Output next values
    // ----------------------------------------
    // Read data stands in the cycle after each cycle of RD, zero otherwise
    wire [7:0] rdata_next = RD ? rd_val : `REG_ZERO;
    // One pulse per deep wake, whichever source came first
    wire por_seq_d = deep_any && !deep_any_q; // RQ17
    // Only the remappable wake function shows the flag, only in sleep
    wire wake_out_d = in_sleep && level_flag; // RQ15
    wire irq_d = |(irq_stat_q & irq_en_q);

    // ----------------------------------------
    // Status registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wake_low_q <= `WAKE_LOW_RST; // RQ9
            wake_high_q <= `WAKE_HIGH_RST;
            context_q <= `CONTEXT_RST;
        end else begin
            wake_low_q <= wake_low_d;
            wake_high_q <= wake_high_d;
            context_q <= context_d;
        end
    end

    // ----------------------------------------
    // Control and interrupt registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wdt_ctrl_q <= `REG_ZERO;
            deep_cfg_q <= `REG_ZERO;
            irq_stat_q <= `REG_ZERO;
            irq_en_q <= `REG_ZERO;
        end else begin
            wdt_ctrl_q <= wdt_ctrl_d;
            deep_cfg_q <= deep_cfg_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= `REG_ZERO;
            deep_any_q <= 1'b0;
            POR_SEQ_START <= 1'b0;
            SLEEP_WAKE_REQ <= 1'b0;
            WAKE_OUT <= 1'b0;
            SINK_EN <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            RDATA <= rdata_next;
            deep_any_q <= deep_any;
            POR_SEQ_START <= por_seq_d;
            SLEEP_WAKE_REQ <= ulp_sleep_ev; // RQ11
            WAKE_OUT <= wake_out_d;
            SINK_EN <= func_en && sink_en; // RQ14
            IRQ <= irq_d;
        end
    end

endmodule : deep_sleep_wake_status

//--- tb/rc_wake_net.sv
// Behavioural capacitor and resistor on the wake pin
`timescale 1ns/1ns
module rc_wake_net #(
    parameter int DISCHARGE = 24
) (
    // Drive and sink
    input wire logic clk,
    input wire logic charge,
    input wire logic sink,
    // Pin level
    output logic level
);
    int cnt = 0;
    // Node stays high until the sink drains it, no leakage otherwise
    always @(posedge clk) begin
        if (charge) begin
            cnt <= DISCHARGE;
        end else if (sink && cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign level = cnt > 0;
endmodule : rc_wake_net

//--- tb/wake_status_chk.sv
// Port checks of the wake status block
`timescale 1ns/1ns
`include "wake_status_regs.svh"
module wake_status_chk (
    // Clock, reset, register port
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Modes and results
    input wire logic SLEEP_MODE,
    input wire logic DEEP_SLEEP_MODE,
    input wire logic SLEEP_WAKE_REQ,
    input wire logic POR_SEQ_START,
    input wire logic WAKE_OUT,
    input wire logic SINK_EN
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_low_gaps;
        $past(RD) && $past(ADDR) == `WAKE_LOW_OFS |-> !RDATA[6] && !RDATA[1];
    endproperty
    a_low_gaps: assert property (p_low_gaps) else $error("low gap bits");
    property p_high_gaps;
        $past(RD) && $past(ADDR) == `WAKE_HIGH_OFS |-> RDATA[7:1] == 7'h00;
    endproperty
    a_high_gaps: assert property (p_high_gaps) else $error("high gap bits");
    property p_por_pulse;
        POR_SEQ_START |=> !POR_SEQ_START;
    endproperty
    a_por_pulse: assert property (p_por_pulse) else $error("long start");
    property p_por_deep;
        POR_SEQ_START |-> $past(DEEP_SLEEP_MODE);
    endproperty
    a_por_deep: assert property (p_por_deep) else $error("start off deep");
    property p_wake_out;
        WAKE_OUT |-> $past(SLEEP_MODE) && !$past(DEEP_SLEEP_MODE);
    endproperty
    a_wake_out: assert property (p_wake_out) else $error("wake out off sleep");
    property p_sleep_wake;
        SLEEP_WAKE_REQ |-> $past(SLEEP_MODE) && !$past(DEEP_SLEEP_MODE);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("wake off sleep");
    property p_sink;
        WR && ADDR == `WDT_CTRL_OFS ##1 !WR |=> SINK_EN == (($past(WDATA, 2) & 8'h03) == 8'h03);
    endproperty
    a_sink: assert property (p_sink) else $error("sink enable");
    property p_ctx;
        WR && ADDR == `CONTEXT_ONE_OFS ##2 RD && ADDR == `CONTEXT_ONE_OFS
            |=> RDATA == $past(WDATA, 3);
    endproperty
    a_ctx: assert property (p_ctx) else $error("context lost");
endmodule : wake_status_chk
bind deep_sleep_wake_status wake_status_chk i_wake_status_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP_MODE(SLEEP_MODE),
    .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .SLEEP_WAKE_REQ(SLEEP_WAKE_REQ),
    .POR_SEQ_START(POR_SEQ_START), .WAKE_OUT(WAKE_OUT), .SINK_EN(SINK_EN));

//--- tb/test_deep_sleep_wake_status.sv
// Self-checking bench of the wake status block
`timescale 1ns/1ns
`include "wake_status_regs.svh"
module test_deep_sleep_wake_status;
    logic clk = 0, rst = 1, wr = 0, rd = 0, slp = 0, dsl = 0, dbe = 0, chg = 0;
    logic [11:0] addr = 0;
    logic [7:0] wdata = 0, ev = 0, rdata, ctx, en;
    logic [15:0] f;
    logic swr, por, wout, sink, irq, pin;
    int n_mismatch = 0, checks = 0, n_por = 0, p0;
    always #5 clk = ~clk;
    always @(posedge clk) if (por) n_por <= n_por + 1;
    deep_sleep_wake_status i_deep_sleep_wake_status (
        .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SLEEP_MODE(slp), .DEEP_SLEEP_MODE(dsl), .DEEP_BOR_ENABLE(dbe), .WAKE_PIN_IN(pin),
        .IOC_IN(ev[0]), .FAULT_IN(ev[1]), .DEEP_WDT_EXPIRED(ev[2]), .ALARM_IN(ev[3]),
        .MASTER_CLEAR_ASSERTED(ev[4]), .POWER_ON_DETECT(ev[5]), .CORE_BROWNOUT(ev[6]),
        .DEEP_BROWNOUT(ev[7]), .SLEEP_WAKE_REQ(swr), .POR_SEQ_START(por), .WAKE_OUT(wout),
        .SINK_EN(sink), .IRQ(irq));
    rc_wake_net i_rc_wake_net (.clk(clk), .charge(chg), .sink(sink), .level(pin));
    // ------
    // Tasks
    // ------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask : wreg
    task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 cmp(rdata, exp);
    endtask : rreg
    // Mode drops only once the synced event has gone, so no tail lands in run mode
    task automatic evt(input int i, input logic deep, input logic b);
        @(posedge clk);
        dsl <= deep;
        dbe <= b;
        ev[i] <= 1;
        repeat (5) @(posedge clk);
        ev[i] <= 0;
        repeat (3) @(posedge clk);
        dsl <= 0;
    endtask : evt
    task automatic cap(input logic deep, input logic dis);
        wreg(`DEEP_CFG_OFS, dis ? 8'h06 : 8'h02);
        wreg(`WDT_CTRL_OFS, 8'h00);
        @(posedge clk);
        chg <= 1;
        repeat (3) @(posedge clk);
        chg <= 0;
        wreg(`WDT_CTRL_OFS, 8'h03);
        @(posedge clk);
        dsl <= deep;
        slp <= !deep;
        repeat (40) @(posedge clk);
    endtask : cap
    function automatic logic [15:0] flags_of(input int i);
        case (i)
            0: return 16'h0100;
            1: return 16'h0080;
            2: return 16'h0010;
            3: return 16'h0008;
            4: return 16'h0004;
            default: return 16'h0001;
        endcase
    endfunction : flags_of
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(28934));
        repeat (3) @(posedge clk);
        rst <= 0;
        rreg(`WAKE_LOW_OFS, 8'h01);
        rreg(12'hF4C, 8'h00);
        wreg(`WAKE_LOW_OFS, 8'hFF);
        rreg(`WAKE_LOW_OFS, 8'hBD);
        wreg(`WAKE_HIGH_OFS, 8'hFF);
        rreg(`WAKE_HIGH_OFS, 8'h01);
        wreg(`WAKE_LOW_OFS, 8'h00);
        wreg(`WAKE_HIGH_OFS, 8'h00);
        for (int i = 0; i < 6; i++) begin
            for (int d = 0; d < 2; d++) begin
                if (i < 5 || d == 0) begin
                    en = $urandom;
                    wreg(`IRQ_EN_OFS, en);
                    rreg(`IRQ_EN_OFS, en);
                    p0 = n_por;
                    evt(i, d[0], 1'b0);
                    f = (d == 1 || i == 5) ? flags_of(i) : 16'h0000;
                    #1 cmp(8'(irq), 8'(|(en & {f[7], f[8], f[5:0]})));
                    cmp(8'(n_por - p0), 8'(d == 1 && i < 5));
                    rreg(`WAKE_LOW_OFS, f[7:0]);
                    rreg(`WAKE_HIGH_OFS, f[15:8]);
                    wreg(`IRQ_CLR_OFS, 8'hFF);
                    @(posedge clk);
                    #1 cmp(8'(irq), 8'h00);
                    wreg(`WAKE_LOW_OFS, 8'h00);
                    wreg(`WAKE_HIGH_OFS, 8'h00);
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            ctx = $urandom;
            wreg(`CONTEXT_ONE_OFS, ctx);
            rreg(`CONTEXT_ONE_OFS, ctx);
            evt(k < 2 ? 7 : 6, k != 2, k == 1);
            rreg(`CONTEXT_ONE_OFS, (k == 1 || k == 2) ? 8'h00 : ctx);
        end
        for (int k = 0; k < 3; k++) begin
            cap(k < 2, k == 1);
            #1 cmp(8'(swr), 8'(k == 2));
            cmp(8'(wout), 8'(k == 2));
            cmp(8'(sink), 8'h01);
            @(posedge clk);
            slp <= 0;
            dsl <= 0;
            rreg(`WAKE_LOW_OFS, k == 0 ? 8'h20 : 8'h00);
            rreg(`WDT_CTRL_OFS, k == 2 ? 8'h23 : 8'h03);
            wreg(`WAKE_LOW_OFS, 8'h00);
        end
        tally_and_finish();
    end
endmodule : test_deep_sleep_wake_status
